// *** rtl/lrxo_pkg.sv ***
// ==========================================================================
// Shared encodings, reset values and helpers for the receive output formatter.
package lrxo_pkg;

  // System-side output format; Gray coded so that neighbours differ in one bit.
  typedef enum logic [1:0] {
    LRXO_FMT_SR_NRZ    = 2'h0,
    LRXO_FMT_DR_NRZ    = 2'h1,
    LRXO_FMT_DR_RZ     = 2'h3,
    LRXO_FMT_DR_SLICED = 2'h2
  } lrxo_fmt_e;

  // Indication output source, in the listed order.
  typedef enum logic [2:0] {
    LRXO_IND_PATTERN   = 3'h0,
    LRXO_IND_ALARM     = 3'h1,
    LRXO_IND_EXZ       = 3'h2,
    LRXO_IND_BPV       = 3'h3,
    LRXO_IND_EXZ_BPV   = 3'h4,
    LRXO_IND_LOS       = 3'h5,
    LRXO_IND_CLOCK     = 3'h6,
    LRXO_IND_SLICE_XOR = 3'h7
  } lrxo_ind_e;

  // ========================================================================
  // Line rates of the recovered clock.
  localparam int LRXO_T1_RATE_KHZ = 1544;
  localparam int LRXO_E1_RATE_KHZ = 2048;

  // ========================================================================
  // Reset values.
  localparam logic LRXO_RST_PD = 1'b1;
  localparam logic LRXO_RST_OE_N = 1'b1;
  localparam logic LRXO_RST_RAIL = 1'b0;
  localparam logic [6:0] LRXO_RST_CFG = 7'h00;

  // ========================================================================
  // Next value of one half of a dual-edge flop whose output is own ^ other.
  function automatic logic lrxo_half_next(input logic act, input logic clr,
                                          input logic data, input logic idle,
                                          input logic own, input logic other);
    logic nxt;
    nxt = own;
    if (act) begin
      nxt = data ^ other;
    end else if (clr) begin
      nxt = idle ^ other;
    end
    return nxt;
  endfunction : lrxo_half_next

  // Indication source multiplexer; the clock source is passed around the flops.
  function automatic logic lrxo_ind_pick(input lrxo_ind_e sel, input logic pattern,
                                         input logic alarm, input logic exz,
                                         input logic bpv, input logic los,
                                         input logic sxor);
    logic v;
    v = 1'b0;
    unique case (sel)
      LRXO_IND_PATTERN: v = pattern;
      LRXO_IND_ALARM: v = alarm;
      LRXO_IND_EXZ: v = exz;
      LRXO_IND_BPV: v = bpv;
      LRXO_IND_EXZ_BPV: v = exz | bpv;
      LRXO_IND_LOS: v = los;
      LRXO_IND_CLOCK: v = 1'b0;
      LRXO_IND_SLICE_XOR: v = sxor;
    endcase
    return v;
  endfunction : lrxo_ind_pick

endpackage : lrxo_pkg

// *** rtl/lrxo_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Two-flop level synchroniser; the first stage feeds only the second.
module lrxo_sync
  import lrxo_pkg::*;
#(
  parameter int W = 7
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } lrxo_sync_s;

  lrxo_sync_s st_q;
  lrxo_sync_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.meta = i_async;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.sync;

endmodule : lrxo_sync
`default_nettype wire

// *** rtl/lrxo_rail_map.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Maps sliced tip and ring pulses onto the positive and negative rails.
module lrxo_rail_map
  import lrxo_pkg::*;
(
  input wire logic i_single_ended,
  input wire logic i_tip_pos,
  input wire logic i_tip_neg,
  input wire logic i_ring_pos,
  input wire logic i_ring_neg,
  output logic o_rail_pos,
  output logic o_rail_neg
);

  always_comb begin
    if (i_single_ended) begin
      // Ring is left open, so only the polarity on tip counts.
      o_rail_pos = i_tip_pos;
      o_rail_neg = i_tip_neg;
    end else begin
      o_rail_pos = i_tip_pos & i_ring_neg;
      o_rail_neg = i_tip_neg & i_ring_pos;
    end
  end

endmodule : lrxo_rail_map
`default_nettype wire

// *** rtl/lrxo_rx_output.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
module lrxo_rx_output
  import lrxo_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_recovered_rx_clock,
  input wire logic [1:0] i_rx_format,
  input wire logic i_rx_data_invert,
  input wire logic i_powerdown_output_state_select,
  input wire logic [2:0] i_indication_source_select,
  input wire logic i_rx_clock_edge_select,
  input wire logic i_rx_powered_down,
  input wire logic i_rx_single_ended,
  input wire logic i_rx_line_tip_pos,
  input wire logic i_rx_line_tip_neg,
  input wire logic i_rx_line_ring_pos,
  input wire logic i_rx_line_ring_neg,
  input wire logic i_decoded_data,
  input wire logic i_pattern_detect,
  input wire logic i_line_alarm_indication,
  input wire logic i_line_excess_zeros,
  input wire logic i_line_bipolar_violation,
  input wire logic i_line_loss_of_signal,
  output logic o_rx_pin_pos_data,
  output logic o_rx_pin_pos_oe_n,
  output logic o_rx_pin_neg_data,
  output logic o_rx_pin_neg_oe_n
);

  // ========================================================================
  // State of the three clocking regions.
  typedef struct packed {
    logic pd;
    logic oe_n;
  } lrxo_ref_s;

  typedef struct packed {
    logic rail_p;
    logic rail_n;
  } lrxo_half_s;

  lrxo_ref_s ref_q;
  lrxo_ref_s ref_d;
  lrxo_half_s rise_q;
  lrxo_half_s rise_d;
  lrxo_half_s fall_q;
  lrxo_half_s fall_d;

  // ========================================================================
  // Configuration crossing into the recovered clock domain.
  // The bits are quasi-static; a change may take a few recovered clock
  // cycles and the formatter may show one mixed cycle while it settles.
  logic [6:0] cfg_raw;
  logic [6:0] cfg_s;
  lrxo_fmt_e fmt_s;
  lrxo_ind_e sel_s;
  logic inv_s;
  logic esel_s;

  assign cfg_raw = {i_rx_format, i_rx_data_invert, i_rx_clock_edge_select,
                    i_indication_source_select};

  lrxo_sync #(
    .W(7)
  ) u_cfg_sync (
    .i_clk(i_recovered_rx_clock),
    .i_rst(i_rst),
    .i_async(cfg_raw),
    .o_sync(cfg_s)
  );

  assign fmt_s = lrxo_fmt_e'(cfg_s[6:5]);
  assign inv_s = cfg_s[4];
  assign esel_s = cfg_s[3];
  assign sel_s = lrxo_ind_e'(cfg_s[2:0]);

  // ========================================================================
  // Rail mapping of the sliced line pulses.
  logic map_p;
  logic map_n;

  lrxo_rail_map u_rail_map (
    .i_single_ended(i_rx_single_ended),
    .i_tip_pos(i_rx_line_tip_pos),
    .i_tip_neg(i_rx_line_tip_neg),
    .i_ring_pos(i_rx_line_ring_pos),
    .i_ring_neg(i_rx_line_ring_neg),
    .o_rail_pos(map_p),
    .o_rail_neg(map_n)
  );

  // ========================================================================
  // Values offered to both edges of the recovered clock.
  logic single_rail;
  logic retimed;
  logic rz_mode;
  logic ind_src;
  logic src_p;
  logic src_n;
  logic idle_n;

  always_comb begin
    single_rail = (fmt_s == LRXO_FMT_SR_NRZ);
    retimed = (fmt_s != LRXO_FMT_DR_SLICED);
    rz_mode = (fmt_s == LRXO_FMT_DR_RZ);
    ind_src = lrxo_ind_pick(sel_s, i_pattern_detect, i_line_alarm_indication,
                            i_line_excess_zeros, i_line_bipolar_violation,
                            i_line_loss_of_signal, map_p ^ map_n);
    if (single_rail) begin
      src_p = i_decoded_data ^ inv_s;
      src_n = ind_src;
      idle_n = 1'b0;
    end else begin
      src_p = map_p ^ inv_s;
      src_n = map_n ^ inv_s;
      idle_n = inv_s;
    end
  end

  // ========================================================================
  // Dual-edge output flops: each rail is rise_q ^ fall_q, so only the
  // selected edge changes it, and RZ returns to idle on the other edge.
  always_comb begin
    rise_d = rise_q;
    if (retimed) begin
      rise_d.rail_p = lrxo_half_next(!esel_s, rz_mode, src_p, inv_s,
                                     rise_q.rail_p, fall_q.rail_p);
      rise_d.rail_n = lrxo_half_next(!esel_s, rz_mode, src_n, idle_n,
                                     rise_q.rail_n, fall_q.rail_n);
    end
  end

  always_ff @(posedge i_recovered_rx_clock or posedge i_rst) begin
    if (i_rst) begin
      rise_q <= '{rail_p: LRXO_RST_RAIL, rail_n: LRXO_RST_RAIL};
    end else begin
      rise_q <= rise_d;
    end
  end

  always_comb begin
    fall_d = fall_q;
    if (retimed) begin
      fall_d.rail_p = lrxo_half_next(esel_s, rz_mode, src_p, inv_s,
                                     fall_q.rail_p, rise_q.rail_p);
      fall_d.rail_n = lrxo_half_next(esel_s, rz_mode, src_n, idle_n,
                                     fall_q.rail_n, rise_q.rail_n);
    end
  end

  always_ff @(negedge i_recovered_rx_clock or posedge i_rst) begin
    if (i_rst) begin
      fall_q <= '{rail_p: LRXO_RST_RAIL, rail_n: LRXO_RST_RAIL};
    end else begin
      fall_q <= fall_d;
    end
  end

  logic val_p;
  logic val_n;

  assign val_p = rise_q.rail_p ^ fall_q.rail_p;
  assign val_n = rise_q.rail_n ^ fall_q.rail_n;

  // ========================================================================
  // Power-down control on the reference clock, which keeps running when
  // the recovered clock has stopped with the receiver.
  always_comb begin
    ref_d = ref_q;
    ref_d.pd = i_rx_powered_down;
    ref_d.oe_n = i_rx_powered_down & i_powerdown_output_state_select;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_q <= '{pd: LRXO_RST_PD, oe_n: LRXO_RST_OE_N};
    end else begin
      ref_q <= ref_d;
    end
  end

  // ========================================================================
  // Pin multiplexing. The sliced and clock paths are combinational on
  // purpose: retiming them would defeat their use as raw line views.
  logic pin_p;
  logic pin_n;

  always_comb begin
    if (fmt_s == LRXO_FMT_DR_SLICED) begin
      pin_p = map_p ^ inv_s;
      pin_n = map_n ^ inv_s;
    end else if (single_rail && sel_s == LRXO_IND_CLOCK) begin
      pin_p = val_p;
      pin_n = i_recovered_rx_clock;
    end else begin
      pin_p = val_p;
      pin_n = val_n;
    end
  end

  assign o_rx_pin_pos_data = ref_q.pd ? 1'b0 : pin_p;
  assign o_rx_pin_neg_data = ref_q.pd ? 1'b0 : pin_n;
  assign o_rx_pin_pos_oe_n = ref_q.oe_n;
  assign o_rx_pin_neg_oe_n = ref_q.oe_n;

  // ========================================================================
  // Checks.
  logic sr_rise;
  logic nrz_rise;
  logic rz_rise;
  logic sr_fall;
  logic nrz_fall;

  assign sr_rise = single_rail && !esel_s;
  assign nrz_rise = (fmt_s == LRXO_FMT_DR_NRZ) && !esel_s;
  assign rz_rise = rz_mode && !esel_s;
  assign sr_fall = single_rail && esel_s;
  assign nrz_fall = (fmt_s == LRXO_FMT_DR_NRZ) && esel_s;

  a_sr_data_edge: assert property (
    @(posedge i_recovered_rx_clock) disable iff (i_rst)
    sr_rise ##1 sr_rise |-> val_p == $past(i_decoded_data ^ inv_s))
    else $error("single-rail data not taken on rising edge");

  a_nrz_both_rails: assert property (
    @(posedge i_recovered_rx_clock) disable iff (i_rst)
    nrz_rise ##1 nrz_rise |-> val_p == $past(map_p ^ inv_s) &&
                            val_n == $past(map_n ^ inv_s))
    else $error("dual-rail NRZ rails not updated on active edge");

  a_rz_return_idle: assert property (
    @(posedge i_recovered_rx_clock) disable iff (i_rst)
    rz_rise [*2] |-> val_p == inv_s && val_n == inv_s)
    else $error("RZ rails did not return to idle level");

  a_ind_active_high: assert property (
    @(posedge i_recovered_rx_clock) disable iff (i_rst)
    (sr_rise && inv_s && sel_s == LRXO_IND_LOS) [*2] |->
    val_n == $past(i_line_loss_of_signal))
    else $error("indication inverted or late");

  a_ind_fall_edge: assert property (
    @(negedge i_recovered_rx_clock) disable iff (i_rst)
    (single_rail && esel_s && sel_s == LRXO_IND_EXZ) [*2] |->
    val_n == $past(i_line_excess_zeros))
    else $error("indication not taken on falling edge");

  a_ind_slice_xor: assert property (
    @(posedge i_recovered_rx_clock) disable iff (i_rst)
    (sr_rise && sel_s == LRXO_IND_SLICE_XOR) [*2] |-> val_n == $past(map_p ^ map_n))
    else $error("slice XOR indication wrong");

  a_diff_rail_map: assert property (
    @(posedge i_recovered_rx_clock) disable iff (i_rst)
    (nrz_rise && !i_rx_single_ended) [*2] |->
    val_p == $past((i_rx_line_tip_pos & i_rx_line_ring_neg) ^ inv_s))
    else $error("differential positive rail mapping wrong");

  a_se_rail_map: assert property (
    @(posedge i_recovered_rx_clock) disable iff (i_rst)
    (nrz_rise && i_rx_single_ended) [*2] |->
    val_n == $past(i_rx_line_tip_neg ^ inv_s))
    else $error("single-ended negative rail mapping wrong");

  a_sliced_raw_pass: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (fmt_s == LRXO_FMT_DR_SLICED && !ref_q.pd) |->
    o_rx_pin_pos_data == (map_p ^ inv_s) && o_rx_pin_neg_data == (map_n ^ inv_s))
    else $error("sliced pulses not passed straight");

  a_powerdown_state: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_rx_powered_down ##1 i_rx_powered_down |->
    o_rx_pin_pos_oe_n == $past(i_powerdown_output_state_select) &&
    o_rx_pin_neg_oe_n == o_rx_pin_pos_oe_n && !o_rx_pin_pos_data && !o_rx_pin_neg_data)
    else $error("powered-down output state wrong");

  a_power_up_drive: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    !i_rx_powered_down ##1 !i_rx_powered_down |->
    !o_rx_pin_pos_oe_n && !o_rx_pin_neg_oe_n)
    else $error("pins not driven while powered up");

  a_pd_pins_low: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    ref_q.pd |-> !o_rx_pin_pos_data && !o_rx_pin_neg_data)
    else $error("data pins not low while powered down");

  a_ind_clock_pass: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (single_rail && sel_s == LRXO_IND_CLOCK && !ref_q.pd) |->
    o_rx_pin_neg_data == i_recovered_rx_clock)
    else $error("recovered clock indication not passed through");

  a_ind_exz_bpv: assert property (
    @(posedge i_recovered_rx_clock) disable iff (i_rst)
    (sr_rise && sel_s == LRXO_IND_EXZ_BPV) [*2] |->
    val_n == $past(i_line_excess_zeros | i_line_bipolar_violation))
    else $error("combined zeros or violation indication wrong");

  a_diff_neg_map: assert property (
    @(posedge i_recovered_rx_clock) disable iff (i_rst)
    (nrz_rise && !i_rx_single_ended) [*2] |->
    val_n == $past((i_rx_line_tip_neg & i_rx_line_ring_pos) ^ inv_s))
    else $error("differential negative rail mapping wrong");

  a_se_pos_map: assert property (
    @(posedge i_recovered_rx_clock) disable iff (i_rst)
    (nrz_rise && i_rx_single_ended) [*2] |->
    val_p == $past(i_rx_line_tip_pos ^ inv_s))
    else $error("single-ended positive rail mapping wrong");

  // With the falling edge active the rising-edge flops must hold, so each
  // rail equals what the previous falling edge took.
  a_sr_fall_edge: assert property (
    @(negedge i_recovered_rx_clock) disable iff (i_rst)
    sr_fall [*2] |-> val_p == $past(i_decoded_data ^ inv_s))
    else $error("single-rail data not taken on falling edge");

  a_nrz_fall_edge: assert property (
    @(negedge i_recovered_rx_clock) disable iff (i_rst)
    nrz_fall [*2] |-> val_p == $past(map_p ^ inv_s) &&
                      val_n == $past(map_n ^ inv_s))
    else $error("dual-rail NRZ rails not taken on falling edge");

endmodule : lrxo_rx_output
`default_nettype wire

// *** tb/lrxo_framer_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Framer model. It samples both pins on the edge opposite the active one,
// mid-bit, so it never races the formatter's clock-to-out.
module lrxo_framer_model (
  input wire logic i_rclk,
  input wire logic i_edge_sel,
  input wire logic i_pos,
  input wire logic i_neg,
  output logic o_pos,
  output logic o_neg
);
  logic [1:0] rise_q;
  logic [1:0] fall_q;
  always @(posedge i_rclk) rise_q <= {i_pos, i_neg};
  always @(negedge i_rclk) fall_q <= {i_pos, i_neg};
  assign {o_pos, o_neg} = i_edge_sel ? rise_q : fall_q;
endmodule : lrxo_framer_model
`default_nettype wire

// *** tb/lrxo_rx_output_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the receive output formatter.
module lrxo_rx_output_test
  import lrxo_pkg::*;
;
  logic i_ref_clk, i_rst, rclk, es, pd, hz, se, inv, dec;
  logic [1:0] fmt;
  logic [2:0] sel;
  logic [3:0] ln;
  logic [4:0] fl;
  logic p, pn, n, nn, fp, fn;
  int n_fail = 0;
  int cmp_count = 0;
  // Nibbles: format, invert, single-ended, tip+/tip-/ring+/ring-, decoded,
  // indication select, flags (two nibbles), expected pos pin, expected neg pin.
  logic [39:0] rows [19] = '{
    40'h0_0_0_0_1_0_10_1_1, 40'h0_1_0_0_1_0_10_0_1, 40'h0_0_0_0_0_1_08_0_1,
    40'h0_0_0_0_0_2_04_0_1, 40'h0_0_0_0_0_3_1d_0_0, 40'h0_0_0_0_0_4_02_0_1,
    40'h0_1_0_0_0_5_01_1_1, 40'h0_0_0_0_0_5_1e_0_0, 40'h0_0_0_0_0_6_00_0_1,
    40'h0_0_1_8_0_7_00_0_1, 40'h1_0_0_9_0_0_00_1_0, 40'h1_0_0_6_0_0_00_0_1,
    40'h1_0_0_8_0_0_00_0_0, 40'h1_0_1_8_0_0_00_1_0, 40'h1_0_1_4_0_0_00_0_1,
    40'h1_1_0_9_0_0_00_0_1, 40'h3_0_0_6_0_0_00_0_1, 40'h2_0_1_4_0_0_00_0_1,
    40'h2_1_1_8_0_0_00_0_1};

  lrxo_rx_output dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_recovered_rx_clock(rclk),
    .i_rx_format(fmt), .i_rx_data_invert(inv), .i_powerdown_output_state_select(hz),
    .i_indication_source_select(sel), .i_rx_clock_edge_select(es),
    .i_rx_powered_down(pd), .i_rx_single_ended(se), .i_rx_line_tip_pos(ln[3]),
    .i_rx_line_tip_neg(ln[2]), .i_rx_line_ring_pos(ln[1]), .i_rx_line_ring_neg(ln[0]),
    .i_decoded_data(dec), .i_pattern_detect(fl[4]), .i_line_alarm_indication(fl[3]),
    .i_line_excess_zeros(fl[2]), .i_line_bipolar_violation(fl[1]),
    .i_line_loss_of_signal(fl[0]), .o_rx_pin_pos_data(p), .o_rx_pin_pos_oe_n(pn),
    .o_rx_pin_neg_data(n), .o_rx_pin_neg_oe_n(nn));

  lrxo_framer_model framer (.i_rclk(rclk), .i_edge_sel(es), .i_pos(p), .i_neg(n),
    .o_pos(fp), .o_neg(fn));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // The odd start offset keeps the two clocks out of phase.
  initial begin
    rclk = 1'b0;
    #3.3;
    forever #16 rclk = ~rclk;
  end

  // ========================================================================
  // Shared tasks.
  task automatic chk(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk

  task automatic step(input int k);
    repeat (k) @(posedge rclk);
    #2;
  endtask : step

  task automatic test_done;
    $display("Checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    #300000;
    n_fail++;
    test_done();
  end

  // ========================================================================
  // Main sequence.
  initial begin
    {i_rst, es, pd, hz, se, inv, dec, fmt, sel, ln, fl} = {1'b1, 20'h0};
    repeat (10) @(posedge i_ref_clk);
    #1;
    chk("rst oe", 1'b1, pn & nn);
    chk("rst data", 1'b0, p | n);
    #1 i_rst = 1'b0;
    foreach (rows[i]) begin
      step(1);
      {fmt, inv, se, ln} = {rows[i][37:36], rows[i][32], rows[i][28], rows[i][27:24]};
      {dec, sel, fl} = {rows[i][20], rows[i][18:16], rows[i][12:8]};
      step(4);
      @(posedge rclk);
      #1;
      chk("pos pin", rows[i][4], p);
      chk("neg pin", rows[i][0], n);
      chk("oe", 1'b0, pn | nn);
    end
    step(1);
    {fmt, inv, se, ln} = {LRXO_FMT_DR_RZ, 2'h0, 4'h9};
    step(4);
    @(posedge rclk);
    #1;
    chk("rz mark", 1'b1, p);
    @(negedge rclk);
    #1;
    chk("rz return", 1'b0, p);
    step(1);
    fmt = LRXO_FMT_DR_SLICED;
    step(4);
    ln = 4'h6;
    #1;
    chk("sliced pos", 1'b0, p);
    chk("sliced neg", 1'b1, n);
    // Inputs change after a rising edge: only a falling active edge may pass them.
    for (int k = 0; k < 4; k++) begin
      step(1);
      fmt = k[1] ? LRXO_FMT_DR_NRZ : LRXO_FMT_SR_NRZ;
      {es, dec, ln, sel, fl} = {k[0], 1'b1, 4'h9, 8'h44};
      step(5);
      {dec, ln, fl} = 10'h0;
      @(negedge rclk);
      #1;
      chk("fall edge", ~es, p);
      chk("fall ind", ~es & ~k[1], n);
      chk("framer", 1'b1, fp);
      chk("framer neg", ~k[1], fn);
      @(posedge rclk);
      #1;
      chk("rise edge", 1'b0, p);
      chk("rise ind", 1'b0, n);
    end
    for (int k = 0; k < 2; k++) begin
      step(1);
      {pd, hz, dec, fmt, ln, sel, fl} = {1'b1, k[0], 1'b1, 2'h0, 4'h9, 3'h0, 5'h1f};
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk("pd oe pos", hz, pn);
      chk("pd oe neg", hz, nn);
      chk("pd data", 1'b0, p | n);
      step(1);
      pd = 1'b0;
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk("up oe", 1'b0, pn | nn);
    end
    // A reset in mid-run must quieten the pins at once and let them drive again.
    step(1);
    i_rst = 1'b1;
    #1;
    chk("mid rst oe", 1'b1, pn & nn);
    chk("mid rst data", 1'b0, p | n);
    repeat (10) @(posedge i_ref_clk);
    #2 i_rst = 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk("post rst oe", 1'b0, pn | nn);
    step(5);
    chk("post rst pos", 1'b1, p);
    chk("post rst neg", 1'b1, n);
    test_done();
  end
endmodule : lrxo_rx_output_test
`default_nettype wire
